/* dv/board_io_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module board_io_properties (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // Host bus
   input wire logic [9:0] io_addr_in,
   input wire logic io_rd_in,
   input wire logic io_wr_in,
   input wire logic [7:0] io_wdata_in,
   input wire logic [7:0] io_rdata_out,
   // Lines and status
   input wire logic [15:0] dio_in,
   input wire logic [15:0] dio_out,
   input wire logic [15:0] dio_oe_out,
   input wire logic cpu_hot_in,
   input wire logic led_drive_out,
   input wire logic watchdog_reset_gate_out,
   input wire logic dio_irq_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   // Writes land one cycle after the strobe
   chk_reset_inputs: assert property ($rose(rst_n_in) |-> dio_oe_out == 16'h0000)
      else $error("lines driven after reset");
   chk_dir_write: assert property (io_wr_in && io_addr_in == 10'h1d3 |=>
      dio_oe_out == {{8{$past(io_wdata_in[1])}}, {8{$past(io_wdata_in[0])}}})
      else $error("direction");
   chk_scr_write: assert property (io_wr_in && io_addr_in == 10'h1d0 |=>
      {led_drive_out, watchdog_reset_gate_out} == {$past(io_wdata_in[7]), $past(io_wdata_in[0])})
      else $error("special control write");
   chk_low_write: assert property (io_wr_in && io_addr_in == 10'h1d4 |=>
      dio_out[7:0] == $past(io_wdata_in)) else $error("low port write");
   chk_high_write: assert property (io_wr_in && io_addr_in == 10'h1d5 |=>
      dio_out[15:8] == $past(io_wdata_in)) else $error("high port write");
   chk_scr_read: assert property (io_rd_in && io_addr_in == 10'h1d0 |=>
      io_rdata_out == {$past(led_drive_out), 1'b0, $past(cpu_hot_in), 4'h0,
      $past(watchdog_reset_gate_out)}) else $error("special control read");
   chk_low_input: assert property (io_rd_in && io_addr_in == 10'h1d4 && !dio_oe_out[0] |=>
      io_rdata_out == $past(dio_in[7:0])) else $error("low input read");
   chk_high_output: assert property (io_rd_in && io_addr_in == 10'h1d5 && dio_oe_out[8]
      |=> io_rdata_out == $past(dio_out[15:8])) else $error("high output read");
   chk_edge_irq: assert property ($changed(dio_in[15:14]) |-> ##[2:5] dio_irq_out)
      else $error("edge without interrupt");
   // Main scenarios reached
   cov_irq: cover property (dio_irq_out);
   cov_out: cover property (dio_oe_out == 16'hffff);
   cov_in_read: cover property (io_rd_in && io_addr_in == 10'h1d4 && !dio_oe_out[0]);
endmodule
bind board_digital_io_and_control_regs board_io_properties board_io_properties_i (
   .sys_clk_in, .rst_n_in, .io_addr_in, .io_rd_in, .io_wr_in, .io_wdata_in, .io_rdata_out,
   .dio_in, .dio_out, .dio_oe_out, .cpu_hot_in, .led_drive_out, .watchdog_reset_gate_out,
   .dio_irq_out);
`default_nettype wire

/* dv/line_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
module line_far_end (
   // Device side
   input wire logic [15:0] dev_level_in,
   input wire logic [15:0] dev_oe_in,
   // Outside source
   input wire logic [15:0] drive_in,
   output logic [15:0] line_out
);
   // Device wins where it drives, outside source elsewhere
   assign line_out = (dev_oe_in & dev_level_in) | (~dev_oe_in & drive_in);
endmodule
`default_nettype wire

/* dv/test_board_digital_io_and_control_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module test_board_digital_io_and_control_regs;
   logic sys_clk_in = 1'b0, rst_n_in = 1'b0, io_rd_in = 1'b0, io_wr_in = 1'b0, cpu_hot_in = 1'b0;
   logic led_drive_out, watchdog_reset_gate_out, dio_irq_out;
   logic [9:0] io_addr_in = 10'h000;
   logic [7:0] io_wdata_in = 8'h00, io_rdata_out;
   logic [11:0] analog_data_in = 12'h000;
   logic [15:0] dio_in, dio_out, dio_oe_out, drv = 16'hffff; // Pulled-up idle lines
   logic done_in = 1'b0, analog_start_out;
   logic [7:0] analog_control_out;
   logic [31:0] seed = 32'h00000003, r;
   int bad_count = 0, comparisons = 0, n;
   // Device and outside lines
   board_digital_io_and_control_regs board_digital_io_and_control_regs_i (.sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in), .io_addr_in(io_addr_in), .io_rd_in(io_rd_in), .io_wr_in(io_wr_in),
      .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out), .dio_in(dio_in), .dio_out(dio_out),
      .dio_oe_out(dio_oe_out), .cpu_hot_in(cpu_hot_in), .led_drive_out(led_drive_out),
      .watchdog_reset_gate_out(watchdog_reset_gate_out), .dio_irq_out(dio_irq_out),
      .analog_data_in(analog_data_in), .analog_done_in(done_in),
      .analog_control_out(analog_control_out), .analog_start_out(analog_start_out));
   line_far_end line_far_end_i (.dev_level_in(dio_out), .dev_oe_in(dio_oe_out), .drive_in(drv),
      .line_out(dio_in));
   // Clock
   initial forever #25 sys_clk_in = ~sys_clk_in;
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [15:0] dirs(input logic [1:0] d);
      return {{8{d[1]}}, {8{d[0]}}};
   endfunction
   task automatic chk(input logic [15:0] g, input logic [15:0] x);
      comparisons++;
      if (g !== x) begin
         bad_count++;
         $display("[FAIL] %0t got %h want %h", $time, g, x);
      end
   endtask
   // One host access, result settled on return
   task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      io_addr_in <= a;
      io_wdata_in <= d;
      io_wr_in <= w;
      io_rd_in <= !w;
      @(posedge sys_clk_in);
      io_wr_in <= 1'b0;
      io_rd_in <= 1'b0;
      #1;
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (5000) @(posedge sys_clk_in);
      bad_count++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      repeat (12) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      #1;
      chk(dio_oe_out, 16'h0000);
      // No false edge flag from the pulled-up lines after reset
      repeat (4) @(posedge sys_clk_in);
      acc(1'b0, 10'h1d2, 8'h00);
      chk(16'(io_rdata_out), 16'h0000);
      repeat (40) begin
         @(posedge sys_clk_in);
         r = xs();
         drv <= r[31:16];
         cpu_hot_in <= r[8];
         analog_data_in <= r[27:16];
         acc(1'b1, 10'h1d3, r[7:0]);
         chk(dio_oe_out, dirs(r[1:0]));
         acc(1'b1, 10'h1d4, r[15:8]);
         acc(1'b1, 10'h1d5, r[23:16]);
         chk(dio_out, r[23:8]);
         acc(1'b0, 10'h1d4, 8'h00);
         chk(16'(io_rdata_out), 16'(r[0] ? r[15:8] : r[23:16]));
         acc(1'b0, 10'h1d5, 8'h00);
         chk(16'(io_rdata_out), 16'(r[1] ? r[23:16] : r[31:24]));
         acc(1'b1, 10'h1d0, r[31:24]);
         chk(16'({led_drive_out, watchdog_reset_gate_out}), 16'({r[31], r[24]}));
         acc(1'b0, 10'h1d0, 8'h00);
         chk(16'(io_rdata_out), 16'({r[31], 1'b0, r[8], 4'h0, r[24]}));
         acc(1'b0, 10'h1d9, 8'h00);
         chk(16'(io_rdata_out), 16'(r[27:24]));
         acc(1'b1, 10'h1d8, r[7:0]);
         chk(16'({analog_start_out, analog_control_out}), 16'({1'b1, r[7:0]}));
         @(posedge sys_clk_in);
         done_in <= 1'b1;
         @(posedge sys_clk_in);
         done_in <= 1'b0;
         acc(1'b0, 10'h1d3, 8'h00);
         chk(16'(io_rdata_out), 16'({1'b1, 5'h00, r[1:0]}));
         acc(1'b0, 10'h1d8, 8'h00);
         chk(16'(io_rdata_out), 16'(r[23:16]));
         acc(1'b0, 10'h1d3, 8'h00);
         chk(16'(io_rdata_out), 16'(r[1:0]));
         acc(1'b0, 10'h1e0, 8'h00);
         chk(16'(io_rdata_out), 16'h0000);
      end
      // Each edge of lines 14 and 15 gives one pulse and a sticky flag
      acc(1'b1, 10'h1d3, 8'h00);
      repeat (6) @(posedge sys_clk_in);
      acc(1'b1, 10'h1d2, 8'h03);
      for (int b = 0; b < 2; b++) begin
         repeat (2) begin
            @(posedge sys_clk_in);
            drv[14 + b] <= !drv[14 + b];
            n = 0;
            repeat (8) begin
               @(posedge sys_clk_in);
               #1;
               n += int'(dio_irq_out === 1'b1);
            end
            chk(16'(n), 16'h0001);
         end
         acc(1'b0, 10'h1d2, 8'h00);
         chk(16'(io_rdata_out), 16'(b + 1));
         acc(1'b1, 10'h1d2, 8'(b + 1));
         acc(1'b0, 10'h1d2, 8'h00);
         chk(16'(io_rdata_out), 16'h0000);
      end
      // Edge and clear in one cycle: the edge wins
      @(posedge sys_clk_in);
      drv[15] <= !drv[15];
      @(posedge sys_clk_in);
      acc(1'b1, 10'h1d2, 8'h02);
      acc(1'b0, 10'h1d2, 8'h00);
      chk(16'(io_rdata_out), 16'h0002);
      // Reset in mid-run with both ports driving
      acc(1'b1, 10'h1d3, 8'h03);
      @(posedge sys_clk_in);
      rst_n_in <= 1'b0;
      repeat (3) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      #1;
      chk(dio_oe_out, 16'h0000);
      tally_and_finish();
   end
endmodule
`default_nettype wire

/* include/board_io_defines.svh */
`ifndef BOARD_IO_DEFINES_SVH
`define BOARD_IO_DEFINES_SVH

// Byte addresses in host I/O space
`define ADDR_SPECIAL_CONTROL 10'h1d0
`define ADDR_JUMPER_STATUS 10'h1d2
`define ADDR_INDUSTRIAL_IO_CONTROL 10'h1d3
`define ADDR_PORT_LOW_DATA 10'h1d4
`define ADDR_PORT_HIGH_DATA 10'h1d5
`define ADDR_ANALOG_LOW 10'h1d8
`define ADDR_ANALOG_HIGH 10'h1d9

// Special control fields
`define SCR_LED_BIT 7
`define SCR_HOT_BIT 5
`define SCR_WDOG_BIT 0

// Industrial I/O control fields
`define IIOC_DONE_BIT 7
`define IIOC_HIGH_DIR_BIT 1
`define IIOC_LOW_DIR_BIT 0

// Jumper and status fields
`define JSR_LINE15_BIT 1
`define JSR_LINE14_BIT 0

// Line positions and port width on the sixteen-line bus
`define LINE15_INDEX 15
`define LINE14_INDEX 14
`define PORT_WIDTH 8

// Zero constants for reset values and read data padding
`define BYTE_ZERO 8'h00
`define NIBBLE_ZERO 4'h0

`endif

/* include/board_io_pkg.sv */
package board_io_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [9:0] io_addr_t;
endpackage

/* verilog/board_digital_io_and_control_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "board_io_defines.svh"

module board_digital_io_and_control_regs (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // Host I/O bus
   input wire logic [9:0] io_addr_in,
   input wire logic io_rd_in,
   input wire logic io_wr_in,
   input wire logic [7:0] io_wdata_in,
   output logic [7:0] io_rdata_out,
   // Digital lines
   input wire logic [15:0] dio_in,
   output logic [15:0] dio_out,
   output logic [15:0] dio_oe_out,
   // Board status and control
   input wire logic cpu_hot_in,
   output logic led_drive_out,
   output logic watchdog_reset_gate_out,
   output logic dio_irq_out,
   // Analog converter side
   input wire logic [11:0] analog_data_in,
   input wire logic analog_done_in,
   output logic [7:0] analog_control_out,
   output logic analog_start_out
);

   // Address match helper
   function automatic logic hit(input board_io_pkg::io_addr_t a, input board_io_pkg::io_addr_t b);
      hit = (a == b);
   endfunction

   // Register state
   board_io_pkg::byte_t port_low_data;
   board_io_pkg::byte_t port_high_data;
   logic low_port_output_select;
   logic high_port_output_select;
   logic led_drive;
   logic watchdog_reset_gate;
   logic line15_edge_flag;
   logic line14_edge_flag;
   logic analog_done;
   board_io_pkg::byte_t analog_control;
   logic analog_start;
   logic [1:0] sync_a;
   logic [1:0] sync_b;
   logic [1:0] sync_prev;
   logic irq_pulse;
   board_io_pkg::byte_t rdata;

   // Next values
   board_io_pkg::byte_t next_port_low_data;
   board_io_pkg::byte_t next_port_high_data;
   logic next_low_port_output_select;
   logic next_high_port_output_select;
   logic next_led_drive;
   logic next_watchdog_reset_gate;
   logic next_line15_edge_flag;
   logic next_line14_edge_flag;
   logic next_analog_done;
   board_io_pkg::byte_t next_analog_control;
   logic next_analog_start;
   logic next_irq_pulse;
   board_io_pkg::byte_t next_rdata;
   logic [1:0] edge_seen;
   logic [1:0] line_now;
   logic [1:0] next_sync_a;
   logic [1:0] next_sync_b;
   logic [1:0] next_sync_prev;

   // Decoded host strobes
   logic wr_special;
   logic wr_flags;
   logic wr_direction;
   logic wr_low_data;
   logic wr_high_data;
   logic wr_analog;
   logic rd_analog;
   assign wr_special = io_wr_in && hit(io_addr_in, `ADDR_SPECIAL_CONTROL);
   assign wr_flags = io_wr_in && hit(io_addr_in, `ADDR_JUMPER_STATUS);
   assign wr_direction = io_wr_in && hit(io_addr_in, `ADDR_INDUSTRIAL_IO_CONTROL);
   assign wr_low_data = io_wr_in && hit(io_addr_in, `ADDR_PORT_LOW_DATA);
   assign wr_high_data = io_wr_in && hit(io_addr_in, `ADDR_PORT_HIGH_DATA);
   assign wr_analog = io_wr_in && hit(io_addr_in, `ADDR_ANALOG_LOW);
   assign rd_analog = io_rd_in && (hit(io_addr_in, `ADDR_ANALOG_LOW) ||
      hit(io_addr_in, `ADDR_ANALOG_HIGH));

   // Edge detect on synchronised top lines
   assign edge_seen = sync_b ^ sync_prev;

   // Port data and direction writes
   always_comb begin
      next_port_low_data = port_low_data;
      next_port_high_data = port_high_data;
      next_low_port_output_select = low_port_output_select;
      next_high_port_output_select = high_port_output_select;
      if (wr_direction) begin
         next_high_port_output_select = io_wdata_in[`IIOC_HIGH_DIR_BIT];
         next_low_port_output_select = io_wdata_in[`IIOC_LOW_DIR_BIT];
      end
      if (wr_low_data) begin
         next_port_low_data = io_wdata_in;
      end
      if (wr_high_data) begin
         next_port_high_data = io_wdata_in;
      end
   end

   // Special control writes, reserved and status bits dropped
   always_comb begin
      next_led_drive = led_drive;
      next_watchdog_reset_gate = watchdog_reset_gate;
      if (wr_special) begin
         next_led_drive = io_wdata_in[`SCR_LED_BIT];
         next_watchdog_reset_gate = io_wdata_in[`SCR_WDOG_BIT];
      end
   end

   // Edge flags and interrupt pulse; a new edge wins over a clear
   always_comb begin
      next_line15_edge_flag = line15_edge_flag;
      next_line14_edge_flag = line14_edge_flag;
      if (wr_flags) begin
         if (io_wdata_in[`JSR_LINE15_BIT]) begin
            next_line15_edge_flag = 1'b0;
         end
         if (io_wdata_in[`JSR_LINE14_BIT]) begin
            next_line14_edge_flag = 1'b0;
         end
      end
      if (edge_seen[1]) begin
         next_line15_edge_flag = 1'b1;
      end
      if (edge_seen[0]) begin
         next_line14_edge_flag = 1'b1;
      end
      next_irq_pulse = |edge_seen;
   end

   // Converter control and done flag; done from the converter wins
   always_comb begin
      next_analog_control = analog_control;
      next_analog_start = 1'b0;
      next_analog_done = analog_done;
      if (wr_analog) begin
         next_analog_control = io_wdata_in;
         next_analog_start = 1'b1;
         next_analog_done = 1'b0;
      end
      if (rd_analog) begin
         next_analog_done = 1'b0; // Reading either converter byte clears done
      end
      if (analog_done_in) begin
         next_analog_done = 1'b1;
      end
   end

   // Synchroniser stages; reset preloads the line level, so release gives no false edge
   always_comb begin
      line_now = {dio_in[`LINE15_INDEX], dio_in[`LINE14_INDEX]};
      next_sync_a = line_now;
      next_sync_b = sync_a;
      next_sync_prev = sync_b;
      if (!rst_n_in) begin
         next_sync_b = line_now;
         next_sync_prev = line_now;
      end
   end

   // Read data mux
   always_comb begin
      next_rdata = `BYTE_ZERO;
      if (hit(io_addr_in, `ADDR_SPECIAL_CONTROL)) begin
         next_rdata[`SCR_LED_BIT] = led_drive;
         next_rdata[`SCR_HOT_BIT] = cpu_hot_in;
         next_rdata[`SCR_WDOG_BIT] = watchdog_reset_gate;
      end else if (hit(io_addr_in, `ADDR_JUMPER_STATUS)) begin
         next_rdata[`JSR_LINE15_BIT] = line15_edge_flag;
         next_rdata[`JSR_LINE14_BIT] = line14_edge_flag;
      end else if (hit(io_addr_in, `ADDR_INDUSTRIAL_IO_CONTROL)) begin
         next_rdata[`IIOC_DONE_BIT] = analog_done;
         next_rdata[`IIOC_HIGH_DIR_BIT] = high_port_output_select;
         next_rdata[`IIOC_LOW_DIR_BIT] = low_port_output_select;
      end else if (hit(io_addr_in, `ADDR_PORT_LOW_DATA)) begin
         next_rdata = low_port_output_select ? port_low_data : dio_in[7:0];
      end else if (hit(io_addr_in, `ADDR_PORT_HIGH_DATA)) begin
         next_rdata = high_port_output_select ? port_high_data : dio_in[15:8];
      end else if (hit(io_addr_in, `ADDR_ANALOG_LOW)) begin
         next_rdata = analog_data_in[7:0];
      end else if (hit(io_addr_in, `ADDR_ANALOG_HIGH)) begin
         next_rdata = {`NIBBLE_ZERO, analog_data_in[11:8]};
      end
      if (!io_rd_in) begin
         next_rdata = rdata;
      end
   end

   // Port registers
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         port_low_data <= `BYTE_ZERO;
         port_high_data <= `BYTE_ZERO;
         low_port_output_select <= 1'b0;
         high_port_output_select <= 1'b0;
      end else begin
         port_low_data <= next_port_low_data;
         port_high_data <= next_port_high_data;
         low_port_output_select <= next_low_port_output_select;
         high_port_output_select <= next_high_port_output_select;
      end
   end

   // Special control registers
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         led_drive <= 1'b0;
         watchdog_reset_gate <= 1'b0;
      end else begin
         led_drive <= next_led_drive;
         watchdog_reset_gate <= next_watchdog_reset_gate;
      end
   end

   // Edge flag and interrupt registers
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         line15_edge_flag <= 1'b0;
         line14_edge_flag <= 1'b0;
         irq_pulse <= 1'b0;
      end else begin
         line15_edge_flag <= next_line15_edge_flag;
         line14_edge_flag <= next_line14_edge_flag;
         irq_pulse <= next_irq_pulse;
      end
   end

   // Converter registers
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         analog_done <= 1'b0;
         analog_control <= `BYTE_ZERO;
         analog_start <= 1'b0;
      end else begin
         analog_done <= next_analog_done;
         analog_control <= next_analog_control;
         analog_start <= next_analog_start;
      end
   end

   // Read data register
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         rdata <= `BYTE_ZERO;
      end else begin
         rdata <= next_rdata;
      end
   end

   // Synchroniser and edge history for lines 15 and 14
   always_ff @(posedge sys_clk_in) begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      sync_prev <= next_sync_prev;
   end

   // Pin drive per port
   genvar g;
   generate
      for (g = 0; g < `PORT_WIDTH; g++) begin : g_lines
         assign dio_out[g] = port_low_data[g];
         assign dio_out[g + `PORT_WIDTH] = port_high_data[g];
         assign dio_oe_out[g] = low_port_output_select;
         assign dio_oe_out[g + `PORT_WIDTH] = high_port_output_select;
      end
   endgenerate

   // Outputs
   assign io_rdata_out = rdata;
   assign led_drive_out = led_drive;
   assign watchdog_reset_gate_out = watchdog_reset_gate;
   assign dio_irq_out = irq_pulse;
   assign analog_control_out = analog_control;
   assign analog_start_out = analog_start;

endmodule

`default_nettype wire
